//--- rtl/idtr_pkg.sv
// Constants, types and helper function for the input delay tap registers
// Overview of operation
// - Other command codes load written value directly
// - Code 001 steps tap up, wraps
// - Code 010 steps tap down, wraps
// - Code 101 adds coarse step, modulo 512
// - Code 110 subtracts coarse step, modulo 512
// - Bits 8:0 read current tap value
// - Value includes alignment; updates keep alignment
// - Command bits 13,14,15, write-only, reset zero
// - Slice 2 at 0x14, slice 3 at 0x15
// - Register load mirrors fabric load, readout bus
// - Tap field read/write, reset zero, 12:9 reserved
package idtr_pkg;

  // ********************************
  // Widths and register map
  // ********************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int TAP_W = 9;
  localparam int NUM_SLICES = 2;
  localparam logic [ADDR_W-1:0] OFS_SLICE2 = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_SLICE3 = 8'h15;
  localparam logic [NUM_SLICES-1:0][ADDR_W-1:0] SLICE_OFS = {OFS_SLICE3, OFS_SLICE2};

  // ********************************
  // Field positions and reset values
  // ********************************
  localparam int TAP_LSB = 0;
  localparam int TAP_MSB = 8;
  localparam int BIT_COARSE = 13;
  localparam int BIT_DOWN = 14;
  localparam int BIT_UP = 15;
  localparam logic [TAP_W-1:0] TAP_RESET = 9'h000;
  localparam logic [TAP_W-1:0] TAP_ONE = 9'h001;
  localparam logic [DATA_W-1:0] RDATA_IDLE = 16'h0000;

  // ********************************
  // Fabric bus placement
  // ********************************
  localparam int FAB_BASE = 18;
  localparam int FAB_LSB_SLICE2 = 18;
  localparam int FAB_LSB_SLICE3 = 27;
  localparam int FAB_W = NUM_SLICES * TAP_W;

  // ********************************
  // Commands {coarse, down, up}
  // ********************************
  localparam logic [2:0] CMD_UP = 3'h1;
  localparam logic [2:0] CMD_DOWN = 3'h2;
  localparam logic [2:0] CMD_COARSE_UP = 3'h5;
  localparam logic [2:0] CMD_COARSE_DOWN = 3'h6;

  // ********************************
  // Register port request
  // ********************************
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } idtr_req_s;

  // Next tap value for one write
  function automatic logic [TAP_W-1:0] idtr_next_tap(
    input logic [TAP_W-1:0] cur,
    input logic [DATA_W-1:0] wdata,
    input logic [TAP_W-1:0] step
  );
    logic [2:0] cmd;
    cmd = {wdata[BIT_COARSE], wdata[BIT_DOWN], wdata[BIT_UP]};
    case (cmd)
      CMD_UP: idtr_next_tap = cur + TAP_ONE;
      CMD_DOWN: idtr_next_tap = cur - TAP_ONE;
      CMD_COARSE_UP: idtr_next_tap = cur + step;
      CMD_COARSE_DOWN: idtr_next_tap = cur - step;
      default: idtr_next_tap = wdata[TAP_MSB:TAP_LSB];
    endcase
  endfunction

endpackage

//--- rtl/idtr_top.sv
// Input delay tap registers for data slices 2 and 3
//
// Chosen here: the plain strobed port.
module idtr_top (
  input wire logic clk,
  input wire logic resetn,
  input wire idtr_pkg::idtr_req_s req,
  input wire logic [idtr_pkg::TAP_W-1:0] coarse_step,
  input wire logic [idtr_pkg::FAB_W-1:0] fabric_delay_load_bus,
  input wire logic [idtr_pkg::NUM_SLICES-1:0] fabric_delay_load,
  output logic [idtr_pkg::DATA_W-1:0] rdata,
  output logic [idtr_pkg::FAB_W-1:0] fabric_delay_readout_bus
);
  import idtr_pkg::*;

  // ********************************
  // Tap value storage
  // ********************************
  logic [NUM_SLICES-1:0][TAP_W-1:0] tap;
  logic [NUM_SLICES-1:0] wr_hit;
  logic [NUM_SLICES-1:0] rd_hit;
  logic [NUM_SLICES-1:0][TAP_W-1:0] next_tap;
  localparam int FAB_POS [NUM_SLICES] = '{FAB_LSB_SLICE2 - FAB_BASE, FAB_LSB_SLICE3 - FAB_BASE};

  for (genvar s = 0; s < NUM_SLICES; s++) begin : g_slice
    assign wr_hit[s] = req.wr && (req.addr == SLICE_OFS[s]);
    assign rd_hit[s] = req.rd && (req.addr == SLICE_OFS[s]);
    assign next_tap[s] = idtr_next_tap(tap[s], req.wdata, coarse_step);

    always_ff @(posedge clk) begin
      if (!resetn) begin
        tap[s] <= TAP_RESET;
      end else if (wr_hit[s]) begin
        tap[s] <= next_tap[s];
      end else if (fabric_delay_load[s]) begin
        tap[s] <= fabric_delay_load_bus[FAB_POS[s] +: TAP_W];
      end
    end

    assign fabric_delay_readout_bus[FAB_POS[s] +: TAP_W] = tap[s];

    // ********************************
    // Slice checks
    // ********************************
    // Direct load checks
    direct_load_a: assert property (@(posedge clk) disable iff (!resetn)
      wr_hit[s] && !(req.wdata[BIT_COARSE:BIT_COARSE] == 1'b0 && (req.wdata[BIT_DOWN]
      ^ req.wdata[BIT_UP])) && !(req.wdata[BIT_COARSE] && (req.wdata[BIT_DOWN]
      ^ req.wdata[BIT_UP]))
      |=> tap[s] == $past(req.wdata[TAP_MSB:TAP_LSB]))
      else $error("direct load wrong");
    step_up_a: assert property (@(posedge clk) disable iff (!resetn)
      wr_hit[s] && {req.wdata[BIT_COARSE], req.wdata[BIT_DOWN], req.wdata[BIT_UP]} == CMD_UP
      |=> tap[s] == TAP_W'($past(tap[s]) + TAP_ONE))
      else $error("step up wrong");
    step_down_a: assert property (@(posedge clk) disable iff (!resetn)
      wr_hit[s] && {req.wdata[BIT_COARSE], req.wdata[BIT_DOWN], req.wdata[BIT_UP]} == CMD_DOWN
      |=> tap[s] == TAP_W'($past(tap[s]) - TAP_ONE))
      else $error("step down wrong");
    coarse_up_a: assert property (@(posedge clk) disable iff (!resetn)
      wr_hit[s] && {req.wdata[BIT_COARSE], req.wdata[BIT_DOWN], req.wdata[BIT_UP]}
      == CMD_COARSE_UP
      |=> tap[s] == TAP_W'($past(tap[s]) + $past(coarse_step)))
      else $error("coarse up wrong");
    coarse_down_a: assert property (@(posedge clk) disable iff (!resetn)
      wr_hit[s] && {req.wdata[BIT_COARSE], req.wdata[BIT_DOWN], req.wdata[BIT_UP]}
      == CMD_COARSE_DOWN
      |=> tap[s] == TAP_W'($past(tap[s]) - $past(coarse_step)))
      else $error("coarse down wrong");
    slice_hold_a: assert property (@(posedge clk) disable iff (!resetn)
      !wr_hit[s] && !fabric_delay_load[s] |=> $stable(tap[s]))
      else $error("slice changed without cause");
    fabric_load_a: assert property (@(posedge clk) disable iff (!resetn)
      fabric_delay_load[s] && !wr_hit[s]
      |=> tap[s] == $past(fabric_delay_load_bus[FAB_POS[s] +: TAP_W]))
      else $error("fabric load wrong");
    write_wins_a: assert property (@(posedge clk) disable iff (!resetn)
      wr_hit[s] && fabric_delay_load[s]
      && {req.wdata[BIT_COARSE], req.wdata[BIT_DOWN], req.wdata[BIT_UP]} == 3'h0
      |=> tap[s] == $past(req.wdata[TAP_MSB:TAP_LSB]))
      else $error("fabric load beat register write");
    tap_reset_a: assert property (@(posedge clk)
      !resetn |=> tap[s] == TAP_RESET)
      else $error("tap not cleared by reset");
    wrap_up_c: cover property (@(posedge clk) disable iff (!resetn)
      wr_hit[s] && tap[s] == 9'h1ff && req.wdata[BIT_UP] && !req.wdata[BIT_DOWN]);
    wrap_down_c: cover property (@(posedge clk) disable iff (!resetn)
      wr_hit[s] && tap[s] == 9'h000 && req.wdata[BIT_DOWN] && !req.wdata[BIT_UP]);
  end

  // ********************************
  // Read port
  // ********************************
  // Tap value readback one cycle later
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rdata <= RDATA_IDLE;
    end else if (rd_hit[0]) begin
      rdata <= {{(DATA_W-TAP_W){1'b0}}, tap[0]};
    end else if (rd_hit[1]) begin
      rdata <= {{(DATA_W-TAP_W){1'b0}}, tap[1]};
    end else begin
      rdata <= RDATA_IDLE;
    end
  end

  // ********************************
  // Read checks
  // ********************************
  read_back_a: assert property (@(posedge clk) disable iff (!resetn)
    rd_hit[1] |=> rdata == {7'h00, $past(tap[1])})
    else $error("slice 3 readback wrong");
  read_slice2_a: assert property (@(posedge clk) disable iff (!resetn)
    rd_hit[0] |=> rdata == {7'h00, $past(tap[0])})
    else $error("slice 2 readback wrong");
  upper_zero_a: assert property (@(posedge clk) disable iff (!resetn)
    rdata[DATA_W-1:TAP_W] == 7'h00)
    else $error("reserved or command bits read nonzero");
  read_idle_a: assert property (@(posedge clk) disable iff (!resetn)
    !(rd_hit[0] || rd_hit[1]) |=> rdata == RDATA_IDLE)
    else $error("read data outside read slot");
  rdata_reset_a: assert property (@(posedge clk)
    !resetn |=> rdata == RDATA_IDLE)
    else $error("read data not cleared by reset");
  readback_c: cover property (@(posedge clk) disable iff (!resetn)
    wr_hit[0] ##1 rd_hit[0]);
  coarse_c: cover property (@(posedge clk) disable iff (!resetn)
    wr_hit[1] && req.wdata[BIT_COARSE] && req.wdata[BIT_UP] && !req.wdata[BIT_DOWN]);

endmodule

//--- test/tb.sv
// Self-checking bench for the input delay tap registers
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import idtr_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  idtr_req_s req = '0;
  logic [TAP_W-1:0] coarse_step = 9'h000;
  logic [FAB_W-1:0] fbus = '0;
  logic [NUM_SLICES-1:0] fload = '0;
  logic [DATA_W-1:0] rdata;
  logic [FAB_W-1:0] rbus;
  logic [TAP_W-1:0] m [NUM_SLICES] = '{9'h000, 9'h000};
  logic [DATA_W-1:0] tbl [10] = '{16'h01ff, 16'h8000, 16'h4000, 16'h01f8, 16'ha000,
    16'h6000, 16'hc0aa, 16'h2155, 16'he0ff, 16'h1e33};
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;
  always #5 clk = ~clk;
  idtr_top DUT (.clk(clk), .resetn(resetn), .req(req), .coarse_step(coarse_step),
    .fabric_delay_load_bus(fbus), .fabric_delay_load(fload), .rdata(rdata),
    .fabric_delay_readout_bus(rbus));
  // ********************************
  // Helpers
  // ********************************
  task automatic check(input logic [FAB_W-1:0] seen, input logic [FAB_W-1:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic [TAP_W-1:0] nxt(input logic [TAP_W-1:0] c,
    input logic [DATA_W-1:0] d, input logic [TAP_W-1:0] s);
    case ({d[13], d[14], d[15]})
      3'h1: return c + 9'h001;
      3'h2: return c - 9'h001;
      3'h5: return c + s;
      3'h6: return c - s;
      default: return d[8:0];
    endcase
  endfunction
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
    input logic [TAP_W-1:0] st);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    coarse_step <= st;
    @(posedge clk);
    req <= '0;
    if (a == OFS_SLICE2) m[0] = nxt(m[0], d, st);
    if (a == OFS_SLICE3) m[1] = nxt(m[1], d, st);
    #1;
    check(rbus, {m[1], m[0]});
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a);
    logic [DATA_W-1:0] e;
    e = (a == OFS_SLICE2) ? {7'h00, m[0]} : (a == OFS_SLICE3) ? {7'h00, m[1]} : 16'h0000;
    @(posedge clk);
    req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req <= '0;
    #1;
    check(18'(rdata), 18'(e));
    @(posedge clk);
    #1;
    check(18'(rdata), 18'h00000);
  endtask
  task automatic fab(input logic [NUM_SLICES-1:0] sel, input logic [FAB_W-1:0] v);
    @(posedge clk);
    fbus <= v;
    fload <= sel;
    @(posedge clk);
    fload <= '0;
    if (sel[0]) m[0] = v[8:0];
    if (sel[1]) m[1] = v[17:9];
    #1;
    check(rbus, {m[1], m[0]});
  endtask
  task automatic clash(input logic [DATA_W-1:0] d, input logic [FAB_W-1:0] v);
    @(posedge clk);
    req <= '{addr: OFS_SLICE2, wdata: d, wr: 1'b1, rd: 1'b0};
    fbus <= v;
    fload <= 2'b11;
    @(posedge clk);
    req <= '0;
    fload <= '0;
    m[0] = nxt(m[0], d, coarse_step);
    m[1] = v[17:9];
    #1;
    check(rbus, {m[1], m[0]});
  endtask
  task automatic give_verdict();
    $display("comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      give_verdict();
    end
  end
  // ********************************
  // Main sequence
  // ********************************
  initial begin
    int s;
    s = $urandom(34);
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    #1;
    check(rbus, 18'h00000);
    rd(OFS_SLICE2);
    rd(OFS_SLICE3);
    $display("test reset done");
    for (int i = 0; i < NUM_SLICES; i++) begin
      foreach (tbl[j]) wr(SLICE_OFS[i], tbl[j], 9'h010);
      rd(SLICE_OFS[i]);
    end
    $display("test commands done");
    wr(8'h13, 16'h0123, 9'h001);
    wr(8'h16, 16'h8000, 9'h001);
    rd(8'h13);
    rd(8'h16);
    $display("test unmapped done");
    for (int k = 1; k < 4; k++) fab(NUM_SLICES'(k), FAB_W'($urandom));
    clash(16'h00aa, {9'h111, 9'h122});
    clash(16'h8000, FAB_W'($urandom));
    rd(OFS_SLICE2);
    rd(OFS_SLICE3);
    $display("test fabric done");
    repeat (300) begin
      s = $urandom_range(3, 0);
      wr((s == 0) ? 8'h16 : SLICE_OFS[s[0]], 16'($urandom), 9'($urandom));
      if (s == 3) rd(SLICE_OFS[$urandom_range(1, 0)]);
    end
    $display("test random done");
    give_verdict();
  end
endmodule
